// *** hdl/stream_pkg.sv ***
package stream_pkg;

	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	localparam int COUNT_W = 22;
	localparam int FIFO_DEPTH = 32;
	// Byte step between consecutive stream words.
	localparam logic [23:0] WORD_STEP = 24'h000004;
	localparam logic [23:0] ADDR_RESET = 24'h000000;
	localparam logic [21:0] COUNT_RESET = 22'h000000;
	// Flash read latency in clocks, from request to returned word.
	localparam int FLASH_LAT = 8;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic stream;
	} flash_req_s;

	typedef enum logic [1:0] {
		IDLE,
		ISSUE,
		WAIT
	} fetch_state_e;

endpackage

// *** hdl/stream_fifo.sv ***
`timescale 1ns/1ps
module stream_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	input wire logic flush
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Ready and valid follow the fill level, so a stalled drain backs up.
	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem[rd_r];

	// Storage has no reset; only the pointers need one.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end

	// A flush empties the FIFO so an aborted stream leaves no stale words.
	always_ff @(posedge clk) begin
		if (!resetn || flush) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= push ? wr_r + 1'b1 : wr_r;
			rd_r <= pop ? rd_r + 1'b1 : rd_r;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // stream_fifo

// *** hdl/flash_stream_prefetch.sv ***
// Behaviour
// - Background fetch of linear words for DMA.
// - Count write of zero aborts active stream.
// - Load during in-flight abort access skips word.
// - Uncached window read stalls while access busy.
`timescale 1ns/1ps
module flash_stream_prefetch #(
	parameter int LAT = stream_pkg::FLASH_LAT,
	parameter int DEPTH = stream_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic addr_wr,
	input wire logic count_wr,
	input wire logic [stream_pkg::ADDR_W-1:0] wr_addr,
	input wire logic [stream_pkg::COUNT_W-1:0] wr_count,
	input wire logic unc_req,
	input wire logic [stream_pkg::ADDR_W-1:0] unc_addr,
	output logic unc_ready,
	output logic [stream_pkg::DATA_W-1:0] unc_data,
	output logic flash_req,
	output logic [stream_pkg::ADDR_W-1:0] flash_addr,
	input wire logic [stream_pkg::DATA_W-1:0] flash_rdata,
	input wire logic flash_rvalid,
	output logic [stream_pkg::DATA_W-1:0] dma_data,
	output logic dma_valid,
	input wire logic dma_ready,
	output logic stream_busy,
	output logic [stream_pkg::COUNT_W-1:0] count_left
);
	stream_pkg::fetch_state_e state_r;
	stream_pkg::flash_req_s cur_r;
	logic [stream_pkg::ADDR_W-1:0] saddr_r;
	logic [stream_pkg::COUNT_W-1:0] scount_r;
	logic skip_r;
	logic stale_r;
	logic [stream_pkg::DATA_W-1:0] fifo_out;
	logic fifo_valid;
	logic fifo_ready;
	logic fifo_in_ready;

	// Byte step applied to the stream address for every word.
	// It is declared ahead of its users so every tool resolves it.
	localparam logic [stream_pkg::ADDR_W-1:0] WSTEP = stream_pkg::WORD_STEP;

	// True when a count value means that no stream is armed.
	// The same test serves the abort decode and the fetch enable,
	// so both always agree on what an empty count is.
	function automatic logic count_idle(
		input logic [stream_pkg::COUNT_W-1:0] c
	);
		return c == '0;
	endfunction

	// Flash access slot is busy from issue until the word returns.
	wire access_busy = (state_r != stream_pkg::IDLE);
	// A zero count write is the abort; it also flushes queued words.
	wire aborting = count_wr && count_idle(wr_count);
	wire count_live = !count_idle(scount_r);
	// Returns are qualified by the slot state so a stray valid is ignored.
	wire ret_any = flash_rvalid && (state_r == stream_pkg::WAIT);
	wire ret_stream = ret_any && cur_r.stream;
	wire ret_unc = ret_any && !cur_r.stream;
	// The last access of an aborted stream still returns a word. Unless it
	// was issued on the abort edge itself, which leaves it unmarked, it is
	// dropped here, so it never reaches the DMA or uses up a count of
	// a stream that software has loaded in the meantime.
	wire ret_stale = ret_stream && stale_r;
	wire ret_live = ret_stream && !stale_r && count_live;
	// An abort on the very edge of a return leaves nothing in flight.
	wire stale_set = aborting && access_busy && cur_r.stream && !ret_any;
	// A reload that overlaps the stale access inherits its increment.
	wire in_flight_aborted = stale_r && !ret_any;
	// Fetching pauses while the FIFO is full or an uncached read waits.
	wire stream_go = count_live && fifo_in_ready && !unc_req;

	// The FIFO absorbs flash latency so DMA reads wait on the bus only while it is empty.
	stream_fifo #(
		.WIDTH(stream_pkg::DATA_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_data(flash_rdata),
		.in_valid(ret_live),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.flush(aborting)
	);

	// Output stage registers the FIFO head for the DMA.
	assign fifo_ready = !dma_valid || dma_ready;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			dma_valid <= 1'b0;
			dma_data <= '0;
		end else if (aborting) begin
			dma_valid <= 1'b0;
		end else if (fifo_ready) begin
			dma_valid <= fifo_valid;
			dma_data <= fifo_out;
		end
	end

	// Address and count registers; count write launches the stream.
	// A fresh start over a still-running aborted access picks up the
	// in-flight increment, reproducing the 4-byte shift faithfully.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			saddr_r <= stream_pkg::ADDR_RESET;
			scount_r <= stream_pkg::COUNT_RESET;
			skip_r <= 1'b0;
		end else begin
			if (addr_wr) begin
				saddr_r <= wr_addr;
				skip_r <= in_flight_aborted;
			end
			if (count_wr) begin
				scount_r <= wr_count;
			end else if (ret_live) begin
				scount_r <= scount_r - 1'b1;
			end
			if (state_r == stream_pkg::IDLE && stream_go && !addr_wr) begin
				saddr_r <= saddr_r + WSTEP;
			end else if (skip_r && ret_stale && !addr_wr) begin
				saddr_r <= saddr_r + WSTEP;
				skip_r <= 1'b0;
			end else if (skip_r && !access_busy) begin
				skip_r <= 1'b0;
			end
		end
	end

	// Marks the access of an aborted stream that is still in flight.
	// The flag lives until that access returns, which is the window in
	// which a reload picks up the extra address step. Software avoids
	// the window with one uncached read, which stalls until it closes.
	// An abort on the edge of the return has nothing left to mark, so
	// there the return wins and the flag stays clear.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stale_r <= 1'b0;
		end else if (stale_set) begin
			stale_r <= 1'b1;
		end else if (ret_any) begin
			stale_r <= 1'b0;
		end
	end

	// Single flash port: uncached reads win arbitration but must wait
	// for any stream access already issued to finish.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_r <= stream_pkg::IDLE;
			cur_r <= '0;
			flash_req <= 1'b0;
			flash_addr <= '0;
			unc_ready <= 1'b0;
			unc_data <= '0;
		end else begin
			flash_req <= 1'b0;
			unc_ready <= 1'b0;
			case (state_r)
				stream_pkg::IDLE: begin
					if (unc_req && !unc_ready) begin
						cur_r <= '{addr: unc_addr, stream: 1'b0};
						flash_addr <= unc_addr;
						flash_req <= 1'b1;
						state_r <= stream_pkg::WAIT;
					end else if (stream_go && !addr_wr) begin
						cur_r <= '{addr: saddr_r, stream: 1'b1};
						flash_addr <= saddr_r;
						flash_req <= 1'b1;
						state_r <= stream_pkg::WAIT;
					end
				end
				stream_pkg::WAIT: begin
					// Any latency is accepted; only one access is open.
					if (flash_rvalid) begin
						state_r <= stream_pkg::IDLE;
						if (ret_unc) begin
							unc_data <= flash_rdata;
							unc_ready <= 1'b1;
						end
					end
				end
				default: state_r <= stream_pkg::IDLE;
			endcase
		end
	end

	// Status outputs are registered copies of the stream state.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stream_busy <= 1'b0;
			count_left <= '0;
		end else begin
			stream_busy <= (scount_r != '0) || access_busy;
			count_left <= scount_r;
		end
	end
endmodule // flash_stream_prefetch

// *** tb/flash_model.sv ***
`timescale 1ns/1ps
module flash_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic flash_req,
	input wire logic [23:0] flash_addr,
	input wire logic [3:0] lat,
	output logic [31:0] flash_rdata,
	output logic flash_rvalid
);
	logic [23:0] a_r;
	logic [3:0] c_r;
	// One read at a time; outside its pulse the data turns to junk.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			c_r <= 4'h0;
			flash_rvalid <= 1'b0;
			flash_rdata <= 32'h0;
		end else begin
			flash_rvalid <= c_r == 4'h1;
			flash_rdata <= c_r == 4'h1 ? {8'ha5, a_r} : ~flash_rdata;
			if (flash_req) begin
				a_r <= flash_addr;
				c_r <= lat;
			end else if (c_r != 4'h0) begin
				c_r <= c_r - 4'h1;
			end
		end
	end
endmodule // flash_model

// *** tb/flash_stream_prefetch_chk.sv ***
`timescale 1ns/1ps
module flash_stream_prefetch_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic count_wr,
	input wire logic [21:0] wr_count,
	input wire logic unc_req,
	input wire logic unc_ready,
	input wire logic flash_req,
	input wire logic [23:0] flash_addr,
	input wire logic flash_rvalid,
	input wire logic dma_valid,
	input wire logic stream_busy,
	input wire logic [21:0] count_left
);
	logic seen_r;
	logic [23:0] last_r;
	// Last stream address; a reload or uncached read restarts the chain.
	always_ff @(posedge clk) begin
		seen_r <= resetn && !count_wr && !unc_req && (seen_r || flash_req);
		if (flash_req)
			last_r <= flash_addr;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_start_reads: assert property (
		count_wr && wr_count != 0 && !stream_busy && !unc_req
		|-> ##2 flash_req)
		else $error("No read after start.");
	a_abort_clears: assert property (
		count_wr && wr_count == 0 |=> !dma_valid ##1 count_left == 0)
		else $error("Abort left words.");
	a_idle_no_read: assert property (
		count_left == 0 && !count_wr && !$past(count_wr) && !unc_req
		|=> !flash_req)
		else $error("Read while idle.");
	a_count_steps: assert property (
		$past(resetn) && $past(resetn, 2) && !$past(count_wr, 2)
		|-> count_left ==
		$past(count_left) || count_left == $past(count_left) - 22'h1)
		else $error("Bad count step.");
	a_addr_steps: assert property (
		flash_req && seen_r |-> flash_addr == last_r + 24'h4)
		else $error("Bad address step.");
	a_unc_waits: assert property (
		unc_ready |-> $past(flash_rvalid))
		else $error("Uncached read did not wait.");
endmodule // flash_stream_prefetch_chk
bind flash_stream_prefetch flash_stream_prefetch_chk chk_inst (.*);

// *** tb/flash_stream_prefetch_test.sv ***
`timescale 1ns/1ps
module flash_stream_prefetch_test;
	logic clk, resetn, addr_wr, count_wr, unc_req, unc_ready, flash_req;
	logic flash_rvalid, dma_valid, dma_ready, stream_busy, stall;
	logic [23:0] wr_addr, unc_addr, flash_addr;
	logic [21:0] wr_count, count_left;
	logic [31:0] unc_data, flash_rdata, dma_data, lfsr, exp_q[$], unc_q[$];
	logic [3:0] lat;
	int errors, comparisons, i, k;
	flash_stream_prefetch #(.LAT(6), .DEPTH(32)) flash_stream_prefetch_inst (.*);
	flash_model flash_model_inst (.clk(clk), .resetn(resetn),
		.flash_req(flash_req), .flash_addr(flash_addr), .lat(lat),
		.flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid));
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] nx(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task cmp(logic [31:0] g, logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task cmp_unc(logic [31:0] g, logic [31:0] e);
		cmp(g, e);
	endtask
	task print_verdict;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Random DMA stalls; heavy stalling lets the FIFO fill up and refuse.
	always @(negedge clk) begin
		lfsr = nx(lfsr);
		dma_ready = stall ? lfsr[2:0] == 3'h0 : lfsr[0] | lfsr[1];
	end
	// Every word the DMA takes must match the oldest noted word.
	always @(posedge clk) begin
		if (resetn && dma_valid && dma_ready)
			cmp(dma_data, exp_q.size() ? exp_q.pop_front() : 32'h0);
		if (resetn && unc_ready && unc_q.size())
			cmp_unc(unc_data, unc_q.pop_front());
	end
	// Address then count; sh is the offset the reload race adds.
	task load(logic [23:0] a, logic [21:0] n, logic [23:0] sh);
		@(negedge clk);
		addr_wr = 1;
		wr_addr = a;
		@(negedge clk);
		addr_wr = 0;
		count_wr = 1;
		wr_count = n;
		for (i = 0; i < n; i++)
			exp_q.push_back({8'ha5, a + sh + 24'(4 * i)});
		@(negedge clk);
		count_wr = 0;
	endtask
	task abort;
		repeat (3) @(negedge clk);
		count_wr = 1;
		wr_count = 0;
		@(negedge clk);
		count_wr = 0;
		exp_q.delete();
	endtask
	task drain;
		for (k = 0; k < 3000 && (exp_q.size() || stream_busy); k++)
			@(negedge clk);
		if (k == 3000) begin
			errors++;
			print_verdict();
		end
	endtask
	// Held until the edge that sees the answer, released after it.
	task unc(logic [23:0] a);
		unc_req = 1;
		unc_addr = a;
		unc_q.push_back({8'ha5, a});
		for (k = 0; k < 300 && unc_ready !== 1; k++)
			@(negedge clk);
		if (k == 300) begin
			errors++;
			print_verdict();
		end
		@(negedge clk);
		unc_req = 0;
	endtask
	initial begin
		{addr_wr, count_wr, unc_req, wr_addr, wr_count, unc_addr} = '0;
		{errors, comparisons, resetn, stall, dma_ready} = '0;
		lfsr = 32'h25f1722f;
		lat = 4'h2;
		repeat (2) @(negedge clk);
		resetn = 1;
		stall = 1;
		load(24'h000100, 22'h28, 24'h0);
		drain();
		stall = 0;
		lat = 4'h9;
		load(24'h002000, 22'h10, 24'h0);
		abort();
		unc(24'h000040);
		load(24'h003000, 22'h3, 24'h0);
		drain();
		load(24'h004000, 22'h10, 24'h0);
		abort();
		load(24'h005000, 22'h3, 24'h4);
		drain();
		print_verdict();
	end
endmodule // flash_stream_prefetch_test
